// File: usp_defs.svh
// Purpose: register offsets, field positions and reset values of the serial port
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   definitions only
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH

`define USP_CTRL_OFS      8'h00
`define USP_DIV_OFS       8'h04
`define USP_TXDATA_OFS    8'h08
`define USP_RXDATA_OFS    8'h0C
`define USP_STATUS_OFS    8'h10

`define USP_CTRL_W        6
`define USP_CTRL_TXEN     0
`define USP_CTRL_RXEN     1
`define USP_CTRL_LOOP     2
`define USP_CTRL_CTSEN    3
`define USP_CTRL_RTSLVL   4
`define USP_CTRL_STOP     5
`define USP_CTRL_RST      6'h00

`define USP_DIV_W         16
`define USP_DIV_RST       16'h0010

`define USP_ST_TXRDY      0
`define USP_ST_RXVLD      1
`define USP_ST_TXBUSY     2
`define USP_ST_OVR        3
`define USP_ST_STOPPED    4
`define USP_ST_CTS        5

`define USP_BUF_W         8
`define USP_BUF_DEPTH     2
`define USP_BUF_CNT_W     2

`endif

// File: usp_pkg.sv
// Purpose: types of the serial port block
// Assumes: usp_defs.svh sizes the fields
// Notes:   whole state of each module is one packed struct
`include "usp_defs.svh"
package usp_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} usp_tx_st_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usp_rx_st_type;

    typedef struct packed {
        logic [`USP_BUF_DEPTH-1:0][`USP_BUF_W-1:0] mem;
        logic                                      wptr;
        logic                                      rptr;
        logic [`USP_BUF_CNT_W-1:0]                 count;
    } usp_buf_type;

    typedef struct packed {
        logic [`USP_CTRL_W-1:0] ctrl;
        logic [`USP_DIV_W-1:0]  div;
        logic [`USP_DIV_W-1:0]  cnt;
        logic                   ser_clk;
        usp_tx_st_type          tx_state;
        logic [7:0]             tx_shift;
        logic [2:0]             tx_bitn;
        logic                   tx_bit;
        logic                   tx_line;
        logic                   rx_s1;
        logic                   rx_s2;
        logic                   rx_s3;
        logic                   cts_s1;
        logic                   cts_s2;
        usp_rx_st_type          rx_state;
        logic [`USP_DIV_W-1:0]  rx_cnt;
        logic [7:0]             rx_shift;
        logic [2:0]             rx_bitn;
        logic                   overrun;
        logic                   rts_n;
        logic [31:0]            rd_data;
    } usp_state_type;
endpackage

// File: usp_buf.sv
// Purpose: two-entry queue with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   push into a full queue is refused; pop from an empty one is ignored
`timescale 1ns/1ps
`default_nettype none
`include "usp_defs.svh"
module usp_buf
    import usp_pkg::*;
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      in_valid_i,
    output logic                           in_ready_o,
    input  wire logic [`USP_BUF_W-1:0]     in_data_i,
    output logic                           out_valid_o,
    input  wire logic                      out_ready_i,
    output logic [`USP_BUF_W-1:0]          out_data_o,
    output logic [`USP_BUF_CNT_W-1:0]      count_o
);
    usp_buf_type st_ff;
    usp_buf_type nxt_st;
    logic        push;
    logic        pop;

    assign in_ready_o  = (st_ff.count != `USP_BUF_CNT_W'(`USP_BUF_DEPTH));
    assign out_valid_o = (st_ff.count != '0);
    assign out_data_o  = st_ff.mem[st_ff.rptr];
    assign count_o     = st_ff.count;

    always_comb begin
        nxt_st = st_ff;
        push   = in_valid_i && in_ready_o;
        pop    = out_ready_i && out_valid_o;
        if (push) begin
            nxt_st.mem[st_ff.wptr] = in_data_i;
            nxt_st.wptr            = ~st_ff.wptr;
        end
        if (pop) begin
            nxt_st.rptr = ~st_ff.rptr;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 2'h1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 2'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// File: usp_uart.sv
// Purpose: asynchronous serial port with automatic handshake lines
// Assumes: 200 MHz sys_clk_i; divider gives clock cycles per bit, at least 2
// Notes:   8 data bits, no parity, one stop bit; two-entry queues both ways
`timescale 1ns/1ps
`default_nettype none
`include "usp_defs.svh"
module usp_uart
    import usp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    output logic             serial_tx_line_o,
    input  wire logic        serial_rx_line_i,
    input  wire logic        clear_to_send_in_n_i,
    output logic             request_to_send_out_n_o
);
    usp_state_type st_ff;
    usp_state_type nxt_st;

    logic                     tx_push;
    logic                     txq_ready;
    logic                     txq_valid;
    logic [7:0]               txq_data;
    logic                     tx_pop;
    logic                     rx_push;
    logic                     rxq_ready;
    logic                     rxq_valid;
    logic [7:0]               rxq_data;
    logic                     rx_pop;
    logic [`USP_BUF_CNT_W-1:0] rxq_count;
    logic                     run;
    logic                     tick;
    logic                     rx_src;

    function automatic logic hits(input logic [`USP_DIV_W-1:0] c, input logic [`USP_DIV_W-1:0] lim);
        // at or past the limit, so a divider lowered mid-count never waits for a 16-bit wrap
        hits = (c >= lim - 16'h1);
    endfunction

    usp_buf u_txq (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (txq_ready),
        .in_data_i   (reg_wdata_i[7:0]),
        .out_valid_o (txq_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (txq_data),
        .count_o     ()
    );

    usp_buf u_rxq (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (rx_push),
        .in_ready_o  (rxq_ready),
        .in_data_i   (st_ff.rx_shift),
        .out_valid_o (rxq_valid),
        .out_ready_i (rx_pop),
        .out_data_o  (rxq_data),
        .count_o     (rxq_count)
    );

    assign reg_rdata_o             = st_ff.rd_data;
    assign serial_tx_line_o        = st_ff.tx_line;
    assign request_to_send_out_n_o = st_ff.rts_n;

    always_comb begin
        nxt_st  = st_ff;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        tx_push = reg_wr_i && (reg_addr_i == `USP_TXDATA_OFS);
        rx_pop  = reg_rd_i && (reg_addr_i == `USP_RXDATA_OFS);
        // pins pass two flops; the third stage only feeds the wake edge detector
        nxt_st.rx_s1  = serial_rx_line_i;
        nxt_st.rx_s2  = st_ff.rx_s1;
        nxt_st.rx_s3  = st_ff.rx_s2;
        nxt_st.cts_s1 = clear_to_send_in_n_i;
        nxt_st.cts_s2 = st_ff.cts_s1;

        if (reg_wr_i) begin
            if (reg_addr_i == `USP_CTRL_OFS) begin
                nxt_st.ctrl = reg_wdata_i[`USP_CTRL_W-1:0];
            end else if (reg_addr_i == `USP_DIV_OFS) begin
                nxt_st.div = reg_wdata_i[`USP_DIV_W-1:0];
            end else if (reg_addr_i == `USP_STATUS_OFS && reg_wdata_i[`USP_ST_OVR]) begin
                nxt_st.overrun = 1'b0;
            end
        end
        // wake wins over a software write in the same cycle
        if (st_ff.ctrl[`USP_CTRL_STOP] && (st_ff.rx_s2 != st_ff.rx_s3)) begin
            nxt_st.ctrl[`USP_CTRL_STOP] = 1'b0;
        end

        run  = !st_ff.ctrl[`USP_CTRL_STOP];
        tick = run && hits(st_ff.cnt, st_ff.div);
        if (run) begin
            nxt_st.cnt = tick ? '0 : st_ff.cnt + 16'h1;
        end
        // serial clock falls at each bit boundary
        nxt_st.ser_clk = (nxt_st.cnt >= (st_ff.div >> 1));

        // abort on the write edge itself, so the line returns to mark together with the control change
        if (!nxt_st.ctrl[`USP_CTRL_TXEN]) begin
            nxt_st.tx_state = TX_IDLE;
            nxt_st.tx_bit   = 1'b1;
        end else begin
            case (st_ff.tx_state)
                TX_IDLE: begin
                    // granted means the line is low
                    if (tick && txq_valid && !(st_ff.ctrl[`USP_CTRL_CTSEN] && st_ff.cts_s2)) begin
                        tx_pop          = 1'b1;
                        nxt_st.tx_shift = txq_data;
                        nxt_st.tx_bit   = 1'b0;
                        nxt_st.tx_bitn  = '0;
                        nxt_st.tx_state = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        nxt_st.tx_bit   = st_ff.tx_shift[0];
                        nxt_st.tx_shift = st_ff.tx_shift >> 1;
                        nxt_st.tx_bitn  = st_ff.tx_bitn + 3'h1;
                        if (st_ff.tx_bitn == 3'h7) begin
                            nxt_st.tx_state = TX_STOP;
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        nxt_st.tx_bit   = 1'b1;
                        nxt_st.tx_state = TX_IDLE;
                    end
                end
            endcase
        end
        nxt_st.tx_line = nxt_st.ctrl[`USP_CTRL_LOOP] ? 1'b1 : nxt_st.tx_bit;

        rx_src = st_ff.ctrl[`USP_CTRL_LOOP] ? st_ff.tx_bit : st_ff.rx_s2;
        if (!st_ff.ctrl[`USP_CTRL_RXEN]) begin
            nxt_st.rx_state = RX_IDLE;
        end else if (run) begin
            nxt_st.rx_cnt = st_ff.rx_cnt + 16'h1;
            case (st_ff.rx_state)
                RX_IDLE: begin
                    nxt_st.rx_cnt = '0;
                    if (!rx_src) begin
                        nxt_st.rx_state = RX_START;
                    end
                end
                RX_START: begin
                    // recheck mid start bit so a glitch does not start a character
                    if (hits(st_ff.rx_cnt, st_ff.div >> 1)) begin
                        nxt_st.rx_cnt   = '0;
                        nxt_st.rx_bitn  = '0;
                        nxt_st.rx_state = rx_src ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (hits(st_ff.rx_cnt, st_ff.div)) begin
                        nxt_st.rx_cnt   = '0;
                        nxt_st.rx_shift = {rx_src, st_ff.rx_shift[7:1]};
                        nxt_st.rx_bitn  = st_ff.rx_bitn + 3'h1;
                        if (st_ff.rx_bitn == 3'h7) begin
                            nxt_st.rx_state = RX_STOP;
                        end
                    end
                end
                default: begin
                    if (hits(st_ff.rx_cnt, st_ff.div)) begin
                        // a bad stop bit drops the character silently
                        if (rx_src) begin
                            rx_push = 1'b1;
                            if (!rxq_ready) begin
                                nxt_st.overrun = 1'b1;
                            end
                        end
                        nxt_st.rx_state = RX_IDLE;
                    end
                end
            endcase
        end

        // low means request made; level mode negates while the queue is full or the receiver is disabled
        if (st_ff.ctrl[`USP_CTRL_RTSLVL]) begin
            nxt_st.rts_n = !(st_ff.ctrl[`USP_CTRL_RXEN] && rxq_count != `USP_BUF_CNT_W'(`USP_BUF_DEPTH));
        end else begin
            nxt_st.rts_n = !st_ff.ctrl[`USP_CTRL_RXEN];
        end

        nxt_st.rd_data = '0;
        if (reg_rd_i) begin
            if (reg_addr_i == `USP_CTRL_OFS) begin
                nxt_st.rd_data[`USP_CTRL_W-1:0] = st_ff.ctrl;
            end else if (reg_addr_i == `USP_DIV_OFS) begin
                nxt_st.rd_data[`USP_DIV_W-1:0] = st_ff.div;
            end else if (reg_addr_i == `USP_RXDATA_OFS) begin
                nxt_st.rd_data[7:0] = rxq_valid ? rxq_data : 8'h00;
            end else if (reg_addr_i == `USP_STATUS_OFS) begin
                nxt_st.rd_data[`USP_ST_TXRDY]   = txq_ready;
                nxt_st.rd_data[`USP_ST_RXVLD]   = rxq_valid;
                nxt_st.rd_data[`USP_ST_TXBUSY]  = (st_ff.tx_state != TX_IDLE);
                nxt_st.rd_data[`USP_ST_OVR]     = st_ff.overrun;
                nxt_st.rd_data[`USP_ST_STOPPED] = st_ff.ctrl[`USP_CTRL_STOP];
                nxt_st.rd_data[`USP_ST_CTS]     = !st_ff.cts_s2;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff         <= '0;
            st_ff.ctrl    <= `USP_CTRL_RST;
            st_ff.div     <= `USP_DIV_RST;
            st_ff.tx_bit  <= 1'b1;
            st_ff.tx_line <= 1'b1;
            st_ff.rx_s1   <= 1'b1;
            st_ff.rx_s2   <= 1'b1;
            st_ff.rx_s3   <= 1'b1;
            st_ff.cts_s1  <= 1'b1;
            st_ff.cts_s2  <= 1'b1;
            st_ff.rts_n   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_TX_MARK: assert property ((st_ff.tx_state == TX_IDLE || st_ff.ctrl[`USP_CTRL_LOOP]) |-> serial_tx_line_o)
        else $error("transmit line not at mark while idle or looped");
    AST_TX_FALL_EDGE: assert property (($changed(serial_tx_line_o) && $stable(st_ff.ctrl)) |-> $fell(st_ff.ser_clk))
        else $error("transmit line changed away from serial clock falling edge");
    AST_TX_LSB: assert property ((st_ff.tx_state == TX_DATA && tick && st_ff.ctrl == $past(st_ff.ctrl))
        ##1 (st_ff.ctrl == $past(st_ff.ctrl)) |-> st_ff.tx_bit == $past(st_ff.tx_shift[0]))
        else $error("transmit bit is not the low bit of the shifter");
    AST_RX_LSB: assert property ((st_ff.rx_state == RX_DATA && run && hits(st_ff.rx_cnt, st_ff.div)
        && st_ff.ctrl[`USP_CTRL_RXEN]) |=> st_ff.rx_shift[7] == $past(rx_src))
        else $error("received bit not shifted in from the top");
    AST_WAKE: assert property ((st_ff.ctrl[`USP_CTRL_STOP] && st_ff.rx_s2 != st_ff.rx_s3) |=> !st_ff.ctrl[`USP_CTRL_STOP])
        else $error("receive line edge did not restart the port clock");
    AST_CTS_HOLD: assert property ((st_ff.tx_state == TX_IDLE && st_ff.ctrl[`USP_CTRL_CTSEN] && st_ff.cts_s2) |=>
        st_ff.tx_state == TX_IDLE)
        else $error("character started without clear-to-send");
    AST_RTS_AUTO: assert property ((!st_ff.ctrl[`USP_CTRL_RTSLVL] && st_ff.ctrl[`USP_CTRL_RXEN])[*2] |-> !request_to_send_out_n_o)
        else $error("request-to-send not asserted while receiving");
    AST_RTS_LEVEL: assert property ((st_ff.ctrl[`USP_CTRL_RTSLVL] && rxq_count == 2'h2)[*2] |-> request_to_send_out_n_o)
        else $error("request-to-send asserted with receive queue full");
    AST_RTS_OFF: assert property ((!st_ff.ctrl[`USP_CTRL_RXEN])[*2] |-> request_to_send_out_n_o)
        else $error("request-to-send asserted while receiver disabled");

    COV_TX_CHAR: cover property (st_ff.tx_state == TX_STOP ##1 st_ff.tx_state == TX_IDLE);
    COV_RX_PUSH: cover property (rx_push && rxq_ready);
    COV_WAKE: cover property ($fell(st_ff.ctrl[`USP_CTRL_STOP]));
    COV_RTS_THROTTLE: cover property (st_ff.ctrl[`USP_CTRL_RTSLVL] && $rose(request_to_send_out_n_o));
endmodule
`default_nettype wire

// File: usp_remote.sv
// Purpose: far-side serial port that sends and decodes 8N1 characters
// Assumes: bit period fixed at BIT_CYC clock cycles, same as the divider the bench programs
// Notes:   decoded characters collect in got_q; a bad stop bit is counted in stop_err
`timescale 1ns/1ps
`default_nettype none
module usp_remote #(
    parameter int BIT_CYC = 4
) (
    input  wire logic sys_clk_i,
    input  wire logic tx_from_dut_i,
    input  wire logic grant_i,
    output logic      rx_to_dut_o,
    output logic      cts_n_o
);
    logic [7:0] got_q[$];
    int         stop_err = 0;

    assign cts_n_o = ~grant_i; // low means permission granted

    initial rx_to_dut_o = 1'b1;

    // characters go out start bit first, then data LSB first, then the stop bit
    task automatic send_byte(input logic [7:0] b);
        @(posedge sys_clk_i);
        rx_to_dut_o <= 1'b0;
        repeat (BIT_CYC) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            rx_to_dut_o <= b[i];
            repeat (BIT_CYC) @(posedge sys_clk_i);
        end
        rx_to_dut_o <= 1'b1;
        repeat (BIT_CYC) @(posedge sys_clk_i);
    endtask

    // sample mid-bit; the start bit is rechecked so a glitch never frames a character
    initial begin : decode
        logic [7:0] b;
        forever begin
            @(posedge sys_clk_i);
            if (tx_from_dut_i === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge sys_clk_i);
                if (tx_from_dut_i === 1'b0) begin
                    for (int i = 0; i < 8; i++) begin
                        repeat (BIT_CYC) @(posedge sys_clk_i);
                        b[i] = tx_from_dut_i;
                    end
                    repeat (BIT_CYC) @(posedge sys_clk_i);
                    if (tx_from_dut_i !== 1'b1) stop_err++;
                    got_q.push_back(b);
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the serial port through its register port and pins
// Assumes: divider programmed to 4 cycles per bit, matching the far-side model
// Notes:   no random stimulus; a cycle ceiling cuts a hang short
`timescale 1ns/1ps
`default_nettype none
`include "usp_defs.svh"
module tb_top;
    localparam int LIMIT = 20000;
    logic        sys_clk  = 1'b0;
    logic        arst_n   = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr   = 1'b0;
    logic        reg_rd   = 1'b0;
    logic [31:0] reg_rdata;
    logic        tx_line;
    logic        rx_line;
    logic        cts_n;
    logic        rts_n;
    logic        grant    = 1'b1;
    logic [31:0] v;
    logic        seen_low;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #2.5 sys_clk = ~sys_clk;

    usp_uart dut (
        .sys_clk_i               (sys_clk),
        .arst_n_i                (arst_n),
        .reg_addr_i              (reg_addr),
        .reg_wdata_i             (reg_wdata),
        .reg_wr_i                (reg_wr),
        .reg_rd_i                (reg_rd),
        .reg_rdata_o             (reg_rdata),
        .serial_tx_line_o        (tx_line),
        .serial_rx_line_i        (rx_line),
        .clear_to_send_in_n_i    (cts_n),
        .request_to_send_out_n_o (rts_n)
    );

    usp_remote #(.BIT_CYC(4)) u_remote (
        .sys_clk_i     (sys_clk),
        .tx_from_dut_i (tx_line),
        .grant_i       (grant),
        .rx_to_dut_o   (rx_line),
        .cts_n_o       (cts_n)
    );

    task automatic give_verdict();
        $display("checks made %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_rx(input int n);
        for (int k = 0; k < 600; k++) begin
            @(posedge sys_clk);
            if (u_remote.got_q.size() >= n) break;
        end
    endtask

    task automatic watch_high(input int n);
        seen_low = 1'b0;
        repeat (n) begin
            @(posedge sys_clk);
            if (tx_line !== 1'b1) seen_low = 1'b1;
        end
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        check({31'h0, tx_line}, 32'h1);
        check({31'h0, rts_n}, 32'h1);
        reg_read(`USP_CTRL_OFS, v);
        check(v, 32'h0);
        reg_read(`USP_DIV_OFS, v);
        check(v, 32'h0000_0010);
        reg_read(8'h20, v);
        check(v, 32'h0);
        // transmitter disabled: queued byte must not leave
        reg_write(`USP_TXDATA_OFS, 32'h0000_00F0);
        watch_high(60);
        check({31'h0, seen_low}, 32'h0);
        reg_write(`USP_DIV_OFS, 32'h0000_0004);
        reg_write(`USP_CTRL_OFS, 32'h0000_0003);
        repeat (3) @(posedge sys_clk);
        check({31'h0, rts_n}, 32'h0);
        wait_rx(1);
        reg_write(`USP_TXDATA_OFS, 32'h0000_00A5);
        reg_write(`USP_TXDATA_OFS, 32'h0000_003C);
        wait_rx(3);
        check({24'h0, u_remote.got_q[0]}, 32'h0000_00F0);
        check({24'h0, u_remote.got_q[1]}, 32'h0000_00A5);
        check({24'h0, u_remote.got_q[2]}, 32'h0000_003C);
        check(u_remote.stop_err, 32'h0);
        watch_high(20);
        check({31'h0, seen_low}, 32'h0);
        u_remote.send_byte(8'h5A);
        repeat (4) @(posedge sys_clk);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h2, 32'h2);
        reg_read(`USP_RXDATA_OFS, v);
        check(v, 32'h0000_005A);
        // permission withheld: character waits in the queue
        grant <= 1'b0;
        reg_write(`USP_CTRL_OFS, 32'h0000_000B);
        reg_write(`USP_TXDATA_OFS, 32'h0000_0081);
        watch_high(80);
        check({31'h0, seen_low}, 32'h0);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h24, 32'h0);
        grant <= 1'b1;
        wait_rx(4);
        check({24'h0, u_remote.got_q[3]}, 32'h0000_0081);
        // level mode: request withdrawn once the receive queue is full
        reg_write(`USP_CTRL_OFS, 32'h0000_0012);
        u_remote.send_byte(8'h11);
        repeat (3) @(posedge sys_clk);
        check({31'h0, rts_n}, 32'h0);
        u_remote.send_byte(8'h22);
        repeat (3) @(posedge sys_clk);
        check({31'h0, rts_n}, 32'h1);
        // a sender that ignores the throttle overruns the full queue; the extra byte is lost
        u_remote.send_byte(8'h33);
        repeat (2) @(posedge sys_clk);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h0A, 32'h0A);
        reg_write(`USP_STATUS_OFS, 32'h0000_0008);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h08, 32'h0);
        reg_read(`USP_RXDATA_OFS, v);
        check(v, 32'h0000_0011);
        repeat (3) @(posedge sys_clk);
        check({31'h0, rts_n}, 32'h0);
        reg_read(`USP_RXDATA_OFS, v);
        check(v, 32'h0000_0022);
        // loopback keeps the pin at mark while data reach the receiver
        reg_write(`USP_CTRL_OFS, 32'h0000_0007);
        reg_write(`USP_TXDATA_OFS, 32'h0000_006E);
        watch_high(80);
        check({31'h0, seen_low}, 32'h0);
        reg_read(`USP_RXDATA_OFS, v);
        check(v, 32'h0000_006E);
        // stopped clock wakes on receive-line activity
        reg_write(`USP_CTRL_OFS, 32'h0000_0020);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h10, 32'h10);
        u_remote.send_byte(8'h00);
        reg_read(`USP_STATUS_OFS, v);
        check(v & 32'h10, 32'h0);
        reg_read(`USP_CTRL_OFS, v);
        check(v & 32'h20, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
